/* core/sbsio_ctrl.sv */
/*
  chip select, pin direction, sleep and burst order logic of a synchronous burst sram.
  assumes a memory core outside that answers mem_addr_out combinationally on
  rd_core_in, and strobe and write decoding outside on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
`include "sbsio_cfg.svh"
module sbsio_ctrl #(
  parameter int ADDR_W = `SBSIO_ADDR_W
) (
  input  wire logic                     clk_in,
  input  wire logic                     srst_in,
  input  wire logic                     chip_sel_first_n_in,
  input  wire logic                     chip_sel_high_in,
  input  wire logic                     chip_sel_third_n_in,
  input  wire logic                     out_en_n_in,
  input  wire logic                     sleep_request_in,
  input  wire logic                     burst_order_in,
  input  wire logic                     addr_load_in,
  input  wire logic                     advance_in,
  input  wire logic                     write_in,
  input  wire logic [ADDR_W-1:0]        addr_in,
  input  wire sbsio_pkg::sbsio_word_s   pin_word_in,
  input  wire sbsio_pkg::sbsio_word_s   rd_core_in,
  output var  sbsio_pkg::sbsio_word_s   pin_word_out,
  output logic                          pin_oe_n_out,
  output var  sbsio_pkg::sbsio_word_s   wr_word_out,
  output logic [ADDR_W-1:0]             mem_addr_out,
  output logic                          selected_out,
  output logic                          sleeping_out
);
  localparam int BW = `SBSIO_BURST_W;

  function automatic logic [BW-1:0] burst_low(input logic [BW-1:0] base,
                                              input logic [BW-1:0] cnt,
                                              input logic          il);
    burst_low = il ? (base ^ cnt) : BW'(base + cnt);
  endfunction

  // pin synchronisers and sleep sequencing
  logic [2:0]              sleep_sync;
  logic [2:0]              order_sync;
  logic                    sleep_lvl;
  logic                    order_lvl;
  sbsio_pkg::sbsio_sleep_e sleep_st;
  logic [2:0]              next_sleep_sync;
  logic [2:0]              next_order_sync;
  logic                    next_sleep_lvl;
  logic                    next_order_lvl;
  sbsio_pkg::sbsio_sleep_e next_sleep_st;
  logic                    next_sleeping;
  logic                    awake;

  assign awake = (sleep_st == sbsio_pkg::SBSIO_AWAKE);

  always_comb begin
    next_sleep_sync = {sleep_sync[1:0], sleep_request_in};
    next_order_sync = {order_sync[1:0], burst_order_in};
    next_sleep_lvl  = sleep_lvl;
    next_order_lvl  = order_lvl;
    // a change counts only once the second and third stages agree
    if (sleep_sync[1] == sleep_sync[2]) begin
      next_sleep_lvl = sleep_sync[2];
    end
    if (order_sync[1] == order_sync[2]) begin
      next_order_lvl = order_sync[2];
    end
    next_sleep_st = sleep_st;
    unique case (sleep_st)
      sbsio_pkg::SBSIO_AWAKE: begin
        if (sleep_lvl) begin
          next_sleep_st = sbsio_pkg::SBSIO_ENTER;
        end
      end
      sbsio_pkg::SBSIO_ENTER: begin
        next_sleep_st = sbsio_pkg::SBSIO_ASLEEP;
      end
      sbsio_pkg::SBSIO_ASLEEP: begin
        if (!sleep_lvl) begin
          next_sleep_st = sbsio_pkg::SBSIO_LEAVE;
        end
      end
      sbsio_pkg::SBSIO_LEAVE: begin
        next_sleep_st = sbsio_pkg::SBSIO_AWAKE;
      end
    endcase
    next_sleeping = (next_sleep_st != sbsio_pkg::SBSIO_AWAKE);
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      // pull defaults: an open sleep pin reads low, an open order pin high
      sleep_sync <= {3{`SBSIO_SLEEP_RST}};
      order_sync <= {3{`SBSIO_ORDER_RST}};
      sleep_lvl  <= `SBSIO_SLEEP_RST;
      order_lvl  <= `SBSIO_ORDER_RST;
      sleep_st   <= sbsio_pkg::SBSIO_AWAKE;
    end else begin
      sleep_sync <= next_sleep_sync;
      order_sync <= next_order_sync;
      sleep_lvl  <= next_sleep_lvl;
      order_lvl  <= next_order_lvl;
      sleep_st   <= next_sleep_st;
    end
  end

  // selection, burst address, write tracking and data registers
  logic                    sel_now;
  logic                    write_seen;
  logic [ADDR_W-1:BW]      addr_hi;
  logic [BW-1:0]           burst_base;
  logic [BW-1:0]           burst_cnt;
  logic                    next_selected;
  logic                    next_write_seen;
  logic [ADDR_W-1:BW]      next_addr_hi;
  logic [BW-1:0]           next_burst_base;
  logic [BW-1:0]           next_burst_cnt;
  logic [ADDR_W-1:0]       next_mem_addr;
  sbsio_pkg::sbsio_word_s  next_wr_word;
  sbsio_pkg::sbsio_word_s  next_pin_word;

  // selected only with all three selects at their active levels
  assign sel_now = !chip_sel_first_n_in && chip_sel_high_in
                   && !chip_sel_third_n_in;

  // direction follows the enable pin without a clock edge; a write in
  // progress or sleep overrides it so the two sides never drive together
  assign pin_oe_n_out = out_en_n_in || write_in || write_seen
                        || !awake;

  always_comb begin
    next_selected   = selected_out;
    next_write_seen = 1'h0;
    next_addr_hi    = addr_hi;
    next_burst_base = burst_base;
    next_burst_cnt  = burst_cnt;
    next_wr_word    = wr_word_out;
    next_pin_word   = pin_word_out;
    if (awake) begin
      next_selected   = sel_now;
      next_write_seen = write_in;
      if (addr_load_in && sel_now) begin
        next_addr_hi    = addr_in[ADDR_W-1:BW];
        next_burst_base = addr_in[BW-1:0];
        next_burst_cnt  = '0;
      end else if (advance_in) begin
        next_burst_cnt = BW'(burst_cnt + 1'h1);
      end
      if (pin_oe_n_out) begin
        next_wr_word = pin_word_in;
      end
      // core answers the address latched at the previous edge
      next_pin_word = rd_core_in;
    end else begin
      // pending accesses are dropped while asleep
      next_selected = 1'h0;
    end
    if (awake) begin
      next_mem_addr = {next_addr_hi,
                       burst_low(next_burst_base, next_burst_cnt, order_lvl)};
    end else begin
      // the order pin keeps syncing in sleep; holding the address keeps it out
      next_mem_addr = mem_addr_out;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      selected_out <= 1'h0;
      write_seen   <= 1'h0;
      addr_hi      <= '0;
      burst_base   <= '0;
      burst_cnt    <= '0;
      mem_addr_out <= '0;
      wr_word_out  <= '0;
      pin_word_out <= '0;
      sleeping_out <= 1'h0;
    end else begin
      selected_out <= next_selected;
      write_seen   <= next_write_seen;
      addr_hi      <= next_addr_hi;
      burst_base   <= next_burst_base;
      burst_cnt    <= next_burst_cnt;
      mem_addr_out <= next_mem_addr;
      wr_word_out  <= next_wr_word;
      pin_word_out <= next_pin_word;
      sleeping_out <= next_sleeping;
    end
  end

  // checks sit beside the logic; all share the one clock and reset
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (srst_in);

  high_select_a: assert property (
    selected_out |-> $past(chip_sel_high_in))
    else $error("selected without the high chip select");

  low_selects_a: assert property (
    selected_out |-> $past(!chip_sel_first_n_in && !chip_sel_third_n_in))
    else $error("selected without both low chip selects");

  drive_enable_a: assert property (
    (!out_en_n_in && !write_in && !write_seen && awake) |-> !pin_oe_n_out)
    else $error("lines not driven with enable low");

  release_enable_a: assert property (
    out_en_n_in |-> pin_oe_n_out)
    else $error("lines driven with enable high");

  sleep_freeze_a: assert property (
    (sleep_st == sbsio_pkg::SBSIO_ASLEEP) |=> $stable(wr_word_out) && $stable(mem_addr_out))
    else $error("state changed while asleep");

  reset_pulls_a: assert property (
    $past(srst_in) |-> (!sleeping_out && order_lvl))
    else $error("pull defaults not taken after reset");

  capture_data_a: assert property (
    ($past(pin_oe_n_out) && $past(awake) && !$past(srst_in))
      |-> wr_word_out == $past(pin_word_in))
    else $error("input word not captured");

  read_data_a: assert property (
    ($past(awake) && !$past(srst_in)) |-> pin_word_out == $past(rd_core_in))
    else $error("read word not from core");

  write_tristate_a: assert property (
    write_in |-> pin_oe_n_out ##1 pin_oe_n_out)
    else $error("lines driven during write");

  linear_step_a: assert property (
    (awake && advance_in && !(addr_load_in && sel_now) && !order_lvl)
      |=> mem_addr_out[1:0] == BW'($past(mem_addr_out[1:0]) + 1'h1))
    else $error("linear burst did not step by one");

  sleep_entry_a: assert property (
    (awake && sleep_lvl) |=> (sleep_st == sbsio_pkg::SBSIO_ENTER)
      ##1 (sleep_st == sbsio_pkg::SBSIO_ASLEEP))
    else $error("sleep entry not two cycles");

  // idle cycles and refusals must leave the core address where it was
  addr_hold_a: assert property (
    (awake && !addr_load_in && !advance_in && $stable(order_lvl) && $past(awake))
      |=> $stable(mem_addr_out))
    else $error("core address moved without load or advance");

  refused_load_a: assert property (
    (awake && addr_load_in && !sel_now && !advance_in && $stable(order_lvl) && $past(awake))
      |=> $stable(mem_addr_out))
    else $error("address taken while not selected");

  interleave_step_a: assert property (
    (awake && advance_in && !(addr_load_in && sel_now) && order_lvl
      && $stable(order_lvl) && $past(awake))
      |=> (mem_addr_out[BW-1:0] ^ $past(mem_addr_out[BW-1:0]))
          == ($past(burst_cnt) ^ BW'($past(burst_cnt) + 1'h1)))
    else $error("interleaved burst did not step by xor");

  load_addr_a: assert property (
    (awake && addr_load_in && sel_now)
      |=> mem_addr_out == $past(addr_in))
    else $error("loaded address not presented to the core");

  sleep_read_a: assert property (
    (sleep_st == sbsio_pkg::SBSIO_ASLEEP)
      |=> $stable(pin_word_out))
    else $error("read word changed while asleep");

  sleep_tristate_a: assert property (
    !awake |-> pin_oe_n_out)
    else $error("lines driven while not awake");

  sleep_select_a: assert property (
    !awake |=> !selected_out)
    else $error("selected while not awake");

  sleep_leave_a: assert property (
    (sleep_st == sbsio_pkg::SBSIO_ASLEEP && !sleep_lvl)
      |=> (sleep_st == sbsio_pkg::SBSIO_LEAVE) ##1 awake)
    else $error("sleep exit not two cycles");

  // a pin level may only move once two sync stages agree
  order_settle_a: assert property (
    $changed(order_lvl)
      |-> $past(order_sync[1] == order_sync[2]))
    else $error("order level moved before sync agreed");

  sleep_settle_a: assert property (
    $changed(sleep_lvl)
      |-> $past(sleep_sync[1] == sleep_sync[2]))
    else $error("sleep level moved before sync agreed");

  capture_hold_a: assert property (
    !pin_oe_n_out
      |=> $stable(wr_word_out))
    else $error("input word captured while lines driven");

  burst_il_c: cover property (
    awake && advance_in && order_lvl ##1 advance_in);
  write_c: cover property (!out_en_n_in ##1 write_in);
  sleep_round_c: cover property (
    sleep_st == sbsio_pkg::SBSIO_LEAVE ##1 awake);
  sel_load_c: cover property (addr_load_in && sel_now ##1 selected_out);
  burst_lin_c: cover property (awake && advance_in && !order_lvl ##1 advance_in);
endmodule // sbsio_ctrl
`default_nettype wire

/* include/sbsio_cfg.svh */
/*
  constants of the burst sram i/o control block: widths, reset values, clock period.
  assumes it is included by bare name before the package and the core.
*/
`ifndef SBSIO_CFG_SVH
`define SBSIO_CFG_SVH
`define SBSIO_DATA_W      16
`define SBSIO_PAR_W       2
`define SBSIO_ADDR_W      18
`define SBSIO_BURST_W     2
`define SBSIO_SLEEP_RST   1'h0
`define SBSIO_ORDER_RST   1'h1
`define SBSIO_CLK_NS      8
`endif

/* include/sbsio_pkg.sv */
/*
  types of the burst sram i/o control block.
  assumes sbsio_cfg.svh is on the include path.
*/
`include "sbsio_cfg.svh"
package sbsio_pkg;
  // one data word together with its two parity bits
  typedef struct packed {
    logic [`SBSIO_PAR_W-1:0]  parity;
    logic [`SBSIO_DATA_W-1:0] data;
  } sbsio_word_s;

  typedef enum logic [1:0] {
    SBSIO_AWAKE = 2'h0,
    SBSIO_ENTER = 2'h1,
    SBSIO_ASLEEP = 2'h3,
    SBSIO_LEAVE = 2'h2
  } sbsio_sleep_e;
endpackage

/* dv/sbsio_core_model.sv */
/*
  memory core stand-in for the burst sram controller: answers a word for an address.
  assumes the controller reads it combinationally in the cycle after the address.
*/
`timescale 1ns/100ps
`default_nettype none
module sbsio_core_model (
  input  wire logic [17:0]            addr_in,
  output var  sbsio_pkg::sbsio_word_s word_out
);
  // pattern from the address: contents known without storage, never lost in sleep
  always_comb begin
    word_out = {addr_in[17:16], addr_in[15:0] ^ 16'h5a3c};
  end
endmodule // sbsio_core_model
`default_nettype wire

/* dv/tb_top.sv */
/*
  self-checking bench of the burst sram i/o control block.
  assumes the package and the core model are compiled before it.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic                   clk_in = 1'b0;
  logic                   srst_in = 1'b1;
  logic                   cs1_n = 1'b1, csh = 1'b0, cs3_n = 1'b1;
  logic                   oe_n = 1'b1, zz = 1'b0, mode = 1'b1;
  logic                   ld = 1'b0, adv = 1'b0, wr = 1'b0;
  logic [17:0]            addr = 18'h0, ea = 18'h0, mem_addr;
  logic                   oe_out, sel, slp;
  sbsio_pkg::sbsio_word_s drv = 18'h0;
  sbsio_pkg::sbsio_word_s pin_in, core, pin_out, wr_word;
  int                     err_count = 0, checked = 0, cyc = 0;
  logic [3:0]             rows [8] = '{4'h0, 4'h2, 4'h5, 4'h6, 4'h8, 4'ha, 4'hc, 4'he};

  always #4 clk_in = ~clk_in;
  // the wire shows the device while it drives, the bench otherwise
  assign pin_in = oe_out ? drv : pin_out;

  sbsio_core_model core_u (.addr_in(mem_addr), .word_out(core));
  sbsio_ctrl #(.ADDR_W(18)) dut_u (
    .clk_in(clk_in), .srst_in(srst_in), .chip_sel_first_n_in(cs1_n),
    .chip_sel_high_in(csh), .chip_sel_third_n_in(cs3_n), .out_en_n_in(oe_n),
    .sleep_request_in(zz), .burst_order_in(mode), .addr_load_in(ld),
    .advance_in(adv), .write_in(wr), .addr_in(addr), .pin_word_in(pin_in),
    .rd_core_in(core), .pin_word_out(pin_out), .pin_oe_n_out(oe_out),
    .wr_word_out(wr_word), .mem_addr_out(mem_addr), .selected_out(sel),
    .sleeping_out(slp));

  task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic test_done;
    if (err_count == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // load base 01, then four advances; seq holds the expected low bits after the first three, first in the top pair
  task automatic burst(input logic m, input logic [5:0] seq);
    @(posedge clk_in);
    mode <= m;
    repeat (6) @(posedge clk_in);
    ld <= 1'b1;
    addr <= 18'h3fffd;
    @(posedge clk_in);
    ld <= 1'b0;
    adv <= 1'b1;
    #1;
    chk(mem_addr, 18'h3fffd);
    chk(18'(oe_out), 18'h0);
    for (int k = 2; k >= 0; k--) begin
      @(posedge clk_in);
      #1;
      chk(18'(mem_addr[1:0]), 18'(seq[2*k+:2]));
      if (k == 2) chk(pin_out, 18'h3a5c1);
    end
    @(posedge clk_in);
    adv <= 1'b0;
  endtask

  // cuts a hang short well beyond the 72 cycles the run needs
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      err_count++;
      test_done();
    end
  end

  initial begin
    repeat (5) @(posedge clk_in);
    srst_in <= 1'b0;
    #1;
    chk(mem_addr, 18'h0);
    chk({sel, slp, wr_word[15:0]}, 18'h0);
    chk(18'(oe_out), 18'h1);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_in);
      {cs1_n, csh, cs3_n} <= rows[i][3:1];
      ld <= 1'b1;
      addr <= {4'(i), 14'h2a5b};
      if (rows[i][0]) ea = {4'(i), 14'h2a5b};
      @(posedge clk_in);
      ld <= 1'b0;
      #1;
      chk(18'(sel), 18'(rows[i][0]));
      chk(mem_addr, ea);
    end
    @(posedge clk_in);
    {cs1_n, csh, cs3_n} <= 3'b010;
    oe_n <= 1'b0;
    burst(1'b1, 6'b001110);
    burst(1'b0, 6'b101100);
    @(posedge clk_in);
    wr <= 1'b1;
    #1;
    chk(18'(oe_out), 18'h1);
    @(posedge clk_in);
    wr <= 1'b0;
    #1;
    chk(18'(oe_out), 18'h1);
    @(posedge clk_in);
    #1;
    chk(18'(oe_out), 18'h0);
    @(posedge clk_in);
    oe_n <= 1'b1;
    // the lines are released a full cycle before the bench drives them
    @(posedge clk_in);
    drv <= 18'h2c3e1;
    @(posedge clk_in);
    #1;
    chk(18'(oe_out), 18'h1);
    chk(wr_word, 18'h2c3e1);
    @(posedge clk_in);
    {cs1_n, csh, cs3_n} <= 3'b101;
    zz <= 1'b1;
    repeat (8) @(posedge clk_in);
    {cs1_n, csh, cs3_n} <= 3'b010;
    ld <= 1'b1;
    addr <= 18'h00004;
    repeat (2) @(posedge clk_in);
    #1;
    chk(18'(slp), 18'h1);
    chk(18'(sel), 18'h0);
    chk(mem_addr, 18'h3fffd);
    @(posedge clk_in);
    {cs1_n, csh, cs3_n} <= 3'b101;
    ld <= 1'b0;
    zz <= 1'b0;
    repeat (8) @(posedge clk_in);
    #1;
    chk(18'(slp), 18'h0);
    test_done();
  end
endmodule // tb_top
`default_nettype wire
